// *** src/sbt_spi_port.sv ***
// Purpose: host serial port of a single-channel serial bus terminal
// Assumes: serial clock below about 1/4 of CLOCK_IN; all pins oversampled
// Notes:   line receiver/driver sit outside; words arrive/leave on plain ports
//
// Summary of operation
// R1: eight clocks after select carry op code
// R2: host sends op code MSB first
// R3: write data MSB follows op code directly
// R4: write lengths 16, 32 per word, 256
// R5: read MSB out on first falling edge
// R6: set/clear/reset act while select still low
// R7: shift only while select is low
// R8: master reset empties both fifos and flags
// R9: rx flag is empty or full by bit 15
// R10: tx flag is empty or full by bit 14
// R11: each fifo holds 32 words of 32
// R12: 256-entry label table filters received words
// R13: bit timing from 1 MHz or divider
// R14: 32nd transmit bit data or parity option
// R15: label bit order reversal option
// R16: independent tx and rx data rates
// R17: status via flag pins or status read
// R18: op 08 reads next rx word, zeros empty
// R19: op 0A shifts out 8-bit status
// R20: op 10 loads 16-bit control word
// R21: op 0E writes up to 32 tx words
// R22: select high aborts transfer, back to idle
`timescale 1ns/1ps
`default_nettype none
module sbt_spi_port
  import sbt_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int AW    = 5
)(
  // clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        MASTER_RESET_IN,
  // serial pins
  input  wire logic        SPI_CS_N_IN,
  input  wire logic        SPI_SCK_IN,
  input  wire logic        SPI_SDI_IN,
  output logic             SPI_SDO_OUT,
  // received words from the line receiver
  input  wire logic [31:0] RX_WORD_IN,
  input  wire logic        RX_WORD_VALID_IN,
  // transmit words to the line driver
  output logic [31:0]      TX_WORD_OUT,
  output logic             TX_WORD_VALID_OUT,
  input  wire logic        TX_WORD_TAKEN_IN,
  // flags and configuration
  output logic             RX_FIFO_FLAG_OUT,
  output logic             TX_FIFO_FLAG_OUT,
  output logic [15:0]      CTRL_OUT,
  output logic [7:0]       CLK_DIV_OUT
);
  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    if (!RST_N_IN) rst_sync_q <= 2'b00;
    else           rst_sync_q <= {rst_sync_q[0], 1'b1};
  assign rst_n = rst_sync_q[1];

  // two stages per pin, then a third stage only for edge detection
  sbt_spi_t s1_q, s2_q, s3_q;
  logic     mr1_q, mr2_q;
  always_ff @(posedge CLOCK_IN or negedge rst_n)
    if (!rst_n)
    begin
      s1_q  <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
      s2_q  <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
      s3_q  <= '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};
      mr1_q <= 1'b0;
      mr2_q <= 1'b0;
    end
    else
    begin
      s1_q  <= '{cs_n: SPI_CS_N_IN, sck: SPI_SCK_IN, sdi: SPI_SDI_IN};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      mr1_q <= MASTER_RESET_IN;
      mr2_q <= mr1_q;
    end

  logic sel, rise, fall;
  assign sel  = !s2_q.cs_n;                          // see R7
  assign rise = sel && s2_q.sck && !s3_q.sck;
  assign fall = sel && !s2_q.sck && s3_q.sck;

  // ----------------------------------------
  // storage: fifos and label table
  // ----------------------------------------
  logic [31:0]    rx_mem [DEPTH];                    // see R11
  logic [31:0]    tx_mem [DEPTH];
  logic [AW:0]    rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
  logic [255:0]   lbl_q;                             // see R12
  logic [15:0]    ctrl_q;
  logic [7:0]     div_q;
  logic           rx_empty, rx_full, tx_empty, tx_full;
  assign rx_empty = rx_wp_q == rx_rp_q;
  assign tx_empty = tx_wp_q == tx_rp_q;
  assign rx_full  = (rx_wp_q[AW] != rx_rp_q[AW]) && (rx_wp_q[AW-1:0] == rx_rp_q[AW-1:0]);
  assign tx_full  = (tx_wp_q[AW] != tx_rp_q[AW]) && (tx_wp_q[AW-1:0] == tx_rp_q[AW-1:0]);

  // label as seen by the filter, optionally bit-reversed
  logic [7:0] rx_lbl;
  always_comb
  begin
    rx_lbl = RX_WORD_IN[7:0];
    if (ctrl_q[CTRL_LBL_REV])                        // see R15
      rx_lbl = {<<{RX_WORD_IN[7:0]}};
  end

  // ----------------------------------------
  // serial sequencer
  // ----------------------------------------
  sbt_state_t  st_q;
  logic [7:0]  op_q;
  logic [8:0]  cnt_q;                                // bits shifted in this phase
  logic [31:0] sh_in_q;
  logic [255:0] sh_out_q;
  logic        cmd_reset, rx_pop, tx_push, ctrl_load, lbl_load, div_load;
  logic        lbl_one_set, lbl_one_clr, lbl_all_set, lbl_all_clr;
  logic [7:0]  op_next;
  logic        is_write;
  assign op_next = {op_q[6:0], s2_q.sdi};            // see R2
  assign is_write = (op_q == OP_CTRL_WR) || (op_q == OP_TX_WR) || (op_q == OP_LBL_WR) ||
                    (op_q == OP_LBL_RST1) || (op_q == OP_LBL_SET1) || (op_q == OP_DIV_WR);

  // status byte: fifo empty/full bits
  logic [7:0] status;
  assign status = {2'b00, tx_full, 1'b0, tx_empty, rx_full, 1'b0, rx_empty}; // see R17

  // one-cycle command strobes
  logic last_op_bit, data_bit;
  assign last_op_bit = (st_q == ST_OP) && rise && (cnt_q == 9'(OP_BITS - 1));
  assign data_bit    = (st_q == ST_DATA) && rise;
  assign cmd_reset   = last_op_bit && (op_next == OP_MRESET);   // see R6
  assign lbl_all_clr = last_op_bit && (op_next == OP_LBL_CLR);
  assign lbl_all_set = last_op_bit && (op_next == OP_LBL_SET);
  assign ctrl_load   = data_bit && op_q == OP_CTRL_WR && cnt_q == 9'(CTRL_BITS - 1); // see R20
  assign tx_push     = data_bit && op_q == OP_TX_WR && cnt_q[4:0] == 5'h1F;          // see R21
  assign lbl_load    = data_bit && op_q == OP_LBL_WR && cnt_q == 9'(LBL_BITS - 1);   // see R4
  assign div_load    = data_bit && op_q == OP_DIV_WR && cnt_q == 9'h007;
  assign lbl_one_set = data_bit && op_q == OP_LBL_SET1 && cnt_q == 9'h007;
  assign lbl_one_clr = data_bit && op_q == OP_LBL_RST1 && cnt_q == 9'h007;
  // pop at the last op code bit of a receive read, as the head word is loaded to shift out
  assign rx_pop      = last_op_bit && (op_next == OP_RX_RD || op_next == OP_RX_DUMP) && !rx_empty;

  // state and counters
  always_ff @(posedge CLOCK_IN or negedge rst_n)
    if (!rst_n)
    begin
      st_q    <= ST_IDLE;
      op_q    <= 8'h00;
      cnt_q   <= 9'h000;
      sh_in_q <= 32'h0000_0000;
    end
    else if (!sel)
    begin
      st_q  <= ST_IDLE;                              // see R22
      cnt_q <= 9'h000;
    end
    else
    begin
      case (st_q)
        ST_IDLE: st_q <= ST_OP;                      // see R1
        ST_OP:
          if (rise)
          begin
            op_q  <= op_next;
            cnt_q <= (cnt_q == 9'(OP_BITS - 1)) ? 9'h000 : cnt_q + 9'h001;
            if (cnt_q == 9'(OP_BITS - 1))
              st_q <= ST_DATA;
          end
        ST_DATA:
          if (rise && is_write)
          begin
            sh_in_q <= {sh_in_q[30:0], s2_q.sdi};    // see R3
            cnt_q   <= (cnt_q == 9'(LBL_BITS - 1)) ? 9'h000 : cnt_q + 9'h001;
            if (op_q != OP_TX_WR && (ctrl_load || lbl_load || div_load ||
                lbl_one_set || lbl_one_clr))
              st_q <= ST_DONE;
          end
        ST_DONE: st_q <= ST_DONE;                    // extra clocks ignored
        default: st_q <= ST_IDLE;
      endcase
    end

  // read shifter: loaded at the last op code bit, shifted on falling edges
  logic rd_first_q;
  always_ff @(posedge CLOCK_IN or negedge rst_n)
    if (!rst_n)
    begin
      sh_out_q    <= '0;
      rd_first_q  <= 1'b0;
      SPI_SDO_OUT <= 1'b0;
    end
    else if (!sel)
    begin
      rd_first_q  <= 1'b0;
      SPI_SDO_OUT <= 1'b0;
    end
    else if (last_op_bit)
    begin
      rd_first_q <= 1'b1;
      case (op_next)
        OP_RX_RD, OP_RX_DUMP:
          sh_out_q <= {(rx_empty ? 32'h0000_0000 : rx_mem[rx_rp_q[AW-1:0]]), 224'h0}; // see R18
        OP_STAT_RD: sh_out_q <= {status, 248'h0};    // see R19
        OP_CTRL_RD: sh_out_q <= {ctrl_q, 240'h0};
        OP_DIV_RD:  sh_out_q <= {div_q, 248'h0};
        OP_LBL_RD:  sh_out_q <= lbl_q;               // bit 255 is label FF
        default:    sh_out_q <= '0;
      endcase
    end
    else if (fall && st_q == ST_DATA)
    begin
      // first falling edge shows the MSB, later ones advance
      if (rd_first_q)
      begin
        SPI_SDO_OUT <= sh_out_q[255];                // see R5
        rd_first_q  <= 1'b0;
      end
      else
      begin
        SPI_SDO_OUT <= sh_out_q[254];
        sh_out_q    <= {sh_out_q[254:0], 1'b0};
      end
    end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge CLOCK_IN or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RESET;
      div_q  <= DIV_RESET;
    end
    else
    begin
      if (ctrl_load) ctrl_q <= {sh_in_q[14:0], s2_q.sdi}; // see R20
      if (div_load)  div_q  <= {sh_in_q[6:0], s2_q.sdi};  // see R13
    end

  // label table; bulk write order is label FF first
  always_ff @(posedge CLOCK_IN or negedge rst_n)
    if (!rst_n)
      lbl_q <= '0;
    else if (lbl_all_clr)
      lbl_q <= '0;                                   // see R6
    else if (lbl_all_set)
      lbl_q <= '1;                                   // see R6
    else if (lbl_one_set)
      lbl_q[{sh_in_q[6:0], s2_q.sdi}] <= 1'b1;
    else if (lbl_one_clr)
      lbl_q[{sh_in_q[6:0], s2_q.sdi}] <= 1'b0;
    else if (data_bit && op_q == OP_LBL_WR)
      lbl_q[8'hFF - cnt_q[7:0]] <= s2_q.sdi;         // see R12

  // ----------------------------------------
  // fifo pointers; master reset by pin or op code
  // ----------------------------------------
  logic mreset, rx_accept, tx_pull;
  assign mreset    = mr2_q || cmd_reset;             // see R8
  assign rx_accept = RX_WORD_VALID_IN && lbl_q[rx_lbl] && !rx_full; // see R12
  assign tx_pull   = TX_WORD_VALID_OUT && TX_WORD_TAKEN_IN;

  always_ff @(posedge CLOCK_IN or negedge rst_n)
    if (!rst_n)
    begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      tx_wp_q <= '0;
      tx_rp_q <= '0;
    end
    else if (mreset)
    begin
      rx_wp_q <= '0;                                 // see R8
      rx_rp_q <= '0;
      tx_wp_q <= '0;
      tx_rp_q <= '0;
    end
    else
    begin
      if (rx_accept) rx_wp_q <= rx_wp_q + (AW+1)'(1);
      if (rx_pop)    rx_rp_q <= rx_rp_q + (AW+1)'(1); // see R18
      if (tx_push && !tx_full) tx_wp_q <= tx_wp_q + (AW+1)'(1); // see R21
      if (tx_pull)   tx_rp_q <= tx_rp_q + (AW+1)'(1);
    end

  // fifo arrays carry no reset; pointers define content
  always_ff @(posedge CLOCK_IN)
  begin
    if (rx_accept) rx_mem[rx_wp_q[AW-1:0]] <= RX_WORD_IN;
    if (tx_push && !tx_full) tx_mem[tx_wp_q[AW-1:0]] <= {sh_in_q[30:0], s2_q.sdi};
  end

  // ----------------------------------------
  // outputs to driver and flag pins
  // ----------------------------------------
  logic [31:0] tx_head;
  always_comb
  begin
    tx_head = tx_mem[tx_rp_q[AW-1:0]];
    if (ctrl_q[CTRL_PAR_EN])                         // see R14
      tx_head[31] = ~^tx_head[30:0];                 // odd parity in bit 32
  end

  always_ff @(posedge CLOCK_IN or negedge rst_n)
    if (!rst_n)
    begin
      RX_FIFO_FLAG_OUT  <= 1'b0;
      TX_FIFO_FLAG_OUT  <= 1'b0;
      TX_WORD_OUT       <= 32'h0000_0000;
      TX_WORD_VALID_OUT <= 1'b0;
      CTRL_OUT          <= CTRL_RESET;
      CLK_DIV_OUT       <= DIV_RESET;
    end
    else
    begin
      RX_FIFO_FLAG_OUT  <= ctrl_q[RX_POL_BIT] ? rx_full : rx_empty; // see R9
      TX_FIFO_FLAG_OUT  <= ctrl_q[TX_POL_BIT] ? tx_full : tx_empty; // see R10
      TX_WORD_OUT       <= tx_head;
      TX_WORD_VALID_OUT <= !tx_empty && !tx_pull && !mreset; // see R16
      CTRL_OUT          <= ctrl_q;                   // rates/clock select used by line logic
      CLK_DIV_OUT       <= div_q;
    end
endmodule // sbt_spi_port
`default_nettype wire

// *** src/sbt_pkg.sv ***
// Purpose: shared constants and types for the serial terminal host port
// Assumes: 25 MHz system clock, host serial clock far slower than that
// Notes:   op codes, flag bit positions and the reset value of the control word
package sbt_pkg;
  // ----------------------------------------
  // instruction op codes
  // ----------------------------------------
  localparam logic [7:0] OP_MRESET  = 8'h01;
  localparam logic [7:0] OP_LBL_CLR = 8'h02;
  localparam logic [7:0] OP_LBL_SET = 8'h03;
  localparam logic [7:0] OP_LBL_RST1 = 8'h04;
  localparam logic [7:0] OP_LBL_SET1 = 8'h05;
  localparam logic [7:0] OP_LBL_WR  = 8'h06;
  localparam logic [7:0] OP_DIV_WR  = 8'h07;
  localparam logic [7:0] OP_RX_RD   = 8'h08;
  localparam logic [7:0] OP_RX_DUMP = 8'h09;
  localparam logic [7:0] OP_STAT_RD = 8'h0A;
  localparam logic [7:0] OP_CTRL_RD = 8'h0B;
  localparam logic [7:0] OP_DIV_RD  = 8'h0C;
  localparam logic [7:0] OP_LBL_RD  = 8'h0D;
  localparam logic [7:0] OP_TX_WR   = 8'h0E;
  localparam logic [7:0] OP_CTRL_WR = 8'h10;
  // ----------------------------------------
  // field positions and lengths
  // ----------------------------------------
  localparam int OP_BITS       = 8;
  localparam int CTRL_BITS     = 16;
  localparam int WORD_BITS     = 32;
  localparam int LBL_BITS      = 256;
  localparam int RX_POL_BIT    = 15;
  localparam int TX_POL_BIT    = 14;
  localparam int CTRL_CLKSEL   = 1;
  localparam int CTRL_LBL_REV  = 12;
  localparam int CTRL_PAR_EN   = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0]  DIV_RESET  = 8'h00;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_OP   = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } sbt_state_t;
  // serial pins grouped after synchronisation
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sdi;
  } sbt_spi_t;
endpackage : sbt_pkg

// *** tb/sbt_spi_monitor.sv ***
// Purpose: port checker for the serial terminal host port
// Assumes: one clock, sees top ports only
// Notes:   bound to the port module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module sbt_spi_monitor
  import sbt_pkg::*;
(
  // clock, reset, pins
  input wire logic        CLOCK_IN,
  input wire logic        RST_N_IN,
  input wire logic        MASTER_RESET_IN,
  input wire logic        SPI_CS_N_IN,
  input wire logic        SPI_SCK_IN,
  // outputs watched
  input wire logic        SPI_SDO_OUT,
  input wire logic        TX_WORD_VALID_OUT,
  input wire logic        RX_FIFO_FLAG_OUT,
  input wire logic        TX_FIFO_FLAG_OUT,
  input wire logic [15:0] CTRL_OUT,
  input wire logic [7:0]  CLK_DIV_OUT
);
  // ----------------------------------------
  // helper: cycles since select went high
  // ----------------------------------------
  logic [3:0] cs_hi_q;
  // saturates so idle stretches never wrap back into a frame
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    if (!RST_N_IN) cs_hi_q <= 4'hF;
    else if (!SPI_CS_N_IN) cs_hi_q <= 4'h0;
    else if (cs_hi_q != 4'hF) cs_hi_q <= cs_hi_q + 4'h1;

  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  ctrl_in_frame_a: assert property ($changed(CTRL_OUT) |-> cs_hi_q < 4'h6)
    else $error("control word changed outside a frame");
  div_in_frame_a: assert property ($changed(CLK_DIV_OUT) |-> cs_hi_q < 4'h6)
    else $error("divider changed outside a frame");
  sdo_idle_low_a: assert property (SPI_CS_N_IN [*5] |-> !SPI_SDO_OUT)
    else $error("serial out active while deselected");
  sdo_steady_a: assert property ((!SPI_CS_N_IN && SPI_SCK_IN) [*4] |-> $stable(SPI_SDO_OUT))
    else $error("serial out moved during clock high");
  rx_flag_mr_a: assert property ($fell(MASTER_RESET_IN) |-> ##3 (RX_FIFO_FLAG_OUT == !CTRL_OUT[RX_POL_BIT]))
    else $error("rx flag wrong after master reset");
  tx_flag_mr_a: assert property ($fell(MASTER_RESET_IN) |-> ##3 (TX_FIFO_FLAG_OUT == !CTRL_OUT[TX_POL_BIT]))
    else $error("tx flag wrong after master reset");
  tx_drop_mr_a: assert property ($fell(MASTER_RESET_IN) |-> ##3 !TX_WORD_VALID_OUT)
    else $error("tx word still offered after master reset");
  reset_vals_a: assert property ($rose(RST_N_IN) |-> CTRL_OUT == CTRL_RESET && CLK_DIV_OUT == DIV_RESET)
    else $error("control or divider not at reset value");
  flags_init_a: assert property ($rose(RST_N_IN) |-> ##4 (RX_FIFO_FLAG_OUT && TX_FIFO_FLAG_OUT))
    else $error("flags not showing empty after reset");

  cover property (!SPI_CS_N_IN && $changed(CTRL_OUT));
  cover property ($fell(MASTER_RESET_IN));
  cover property ($rose(TX_FIFO_FLAG_OUT) && CTRL_OUT[TX_POL_BIT]);
endmodule // sbt_spi_monitor

bind sbt_spi_port sbt_spi_monitor mon_u (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
  .MASTER_RESET_IN(MASTER_RESET_IN), .SPI_CS_N_IN(SPI_CS_N_IN), .SPI_SCK_IN(SPI_SCK_IN),
  .SPI_SDO_OUT(SPI_SDO_OUT), .TX_WORD_VALID_OUT(TX_WORD_VALID_OUT),
  .RX_FIFO_FLAG_OUT(RX_FIFO_FLAG_OUT), .TX_FIFO_FLAG_OUT(TX_FIFO_FLAG_OUT),
  .CTRL_OUT(CTRL_OUT), .CLK_DIV_OUT(CLK_DIV_OUT));
`default_nettype wire

// *** tb/sbt_spi_host.sv ***
// Purpose: behavioural serial master driving the port
// Assumes: clock half phase of 5 system cycles
// Notes:   clock idles low, data idles at its pull-down level
`timescale 1ns/1ps
`default_nettype none
module sbt_spi_host (
  // system clock and returned data
  input  wire logic clk_in,
  input  wire logic sdo_in,
  // serial pins driven
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      sdi_out
);
  // deselected and still between frames
  initial
  begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    sdi_out  = 1'b0;
  end
  // every change lands just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic open_frame;
    tick(1);
    cs_n_out = 1'b0;
    tick(4);
  endtask
  // msb first; data set at the fall, read data taken at the rise
  task automatic shift(input logic [31:0] d, input int n, output logic [31:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_out = d[i];
      tick(5);
      sck_out = 1'b1;
      r = {r[30:0], sdo_in};
      tick(5);
      sck_out = 1'b0;
    end
  endtask
  task automatic close_frame;
    tick(5);
    cs_n_out = 1'b1;
    sdi_out  = 1'b0;
    tick(6);
  endtask
endmodule // sbt_spi_host
`default_nettype wire

// *** tb/sbt_spi_port_test.sv ***
// Purpose: self-checking bench for the serial terminal host port
// Assumes: 25 MHz clock, master model in sbt_spi_host
// Notes:   frames are op code then data, read data comes back in rd
`timescale 1ns/1ps
`default_nettype none
module sbt_spi_port_test;
  import sbt_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n, mr, cs_n, sck, sdi, sdo, rx_v, tx_v, tx_tk, rx_fifo_flag, tx_fifo_flag;
  logic [31:0] rx_w, tx_w, rd;
  logic [15:0] ctrl;
  logic [7:0]  cdiv;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #20 clk = ~clk;

  sbt_spi_host host_u (.clk_in(clk), .sdo_in(sdo), .cs_n_out(cs_n), .sck_out(sck), .sdi_out(sdi));
  sbt_spi_port dut_u (.CLOCK_IN(clk), .RST_N_IN(rst_n), .MASTER_RESET_IN(mr),
    .SPI_CS_N_IN(cs_n), .SPI_SCK_IN(sck), .SPI_SDI_IN(sdi), .SPI_SDO_OUT(sdo),
    .RX_WORD_IN(rx_w), .RX_WORD_VALID_IN(rx_v), .TX_WORD_OUT(tx_w),
    .TX_WORD_VALID_OUT(tx_v), .TX_WORD_TAKEN_IN(tx_tk), .RX_FIFO_FLAG_OUT(rx_fifo_flag),
    .TX_FIFO_FLAG_OUT(tx_fifo_flag), .CTRL_OUT(ctrl), .CLK_DIV_OUT(cdiv));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bulk label pattern: labels FF, FD, FC and 00 enabled
  function automatic logic [31:0] lbl_pat(input int i);
    return (i == 0) ? 32'hB000_0000 : {31'h0, i == 7};
  endfunction
  // one whole frame; n of zero sends the op code alone
  task automatic cmd(input logic [7:0] op, input logic [31:0] d, input int n);
    host_u.open_frame();
    host_u.shift({24'h0, op}, 8, rd);
    if (n > 0) host_u.shift(d, n, rd);
    host_u.close_frame();
  endtask
  task automatic push(input logic [31:0] w);
    host_u.tick(1);
    rx_w = w;
    rx_v = 1'b1;
    host_u.tick(1);
    rx_v = 1'b0;
    host_u.tick(3);
  endtask

  // hang guard: the sequence needs roughly 22000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0; mr = 1'b0; rx_w = 32'h0; rx_v = 1'b0; tx_tk = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    host_u.tick(6);
    chk("ctrl", ctrl, CTRL_RESET);
    chk("flags", {rx_fifo_flag, tx_fifo_flag}, 2'b11);
    cmd(OP_CTRL_WR, 32'hC000, CTRL_BITS);
    chk("ctrl", ctrl, 32'hC000);
    chk("flags", {rx_fifo_flag, tx_fifo_flag}, 2'b00);
    cmd(OP_STAT_RD, 32'h0, 8);
    chk("status", rd, 32'h09);
    cmd(OP_DIV_WR, 32'h0A, 8);
    chk("div", cdiv, 8'h0A);
    cmd(OP_DIV_RD, 32'h0, 8);
    chk("div rd", rd, 32'h0A);
    // abort mid data, then a fresh read must decode cleanly
    host_u.open_frame();
    host_u.shift({24'h0, OP_CTRL_WR}, 8, rd);
    host_u.shift(32'h3, 4, rd);
    host_u.close_frame();
    chk("ctrl", ctrl, 32'hC000);
    cmd(OP_CTRL_RD, 32'h0, CTRL_BITS);
    chk("ctrl rd", rd, 32'hC000);
    // one frame of 33 words: the last one meets a full fifo
    host_u.open_frame();
    host_u.shift({24'h0, OP_TX_WR}, 8, rd);
    for (int i = 0; i < 33; i++) host_u.shift(32'h25000000 + i, WORD_BITS, rd);
    host_u.close_frame();
    chk("tx_fifo_flag", tx_fifo_flag, 1'b1);
    cmd(OP_STAT_RD, 32'h0, 8);
    chk("status", rd, 32'h21);
    for (int i = 0; i < 32; i++)
    begin
      chk("tx word", tx_w, 32'h25000000 + i);
      host_u.tick(1);
      tx_tk = 1'b1;
      host_u.tick(1);
      tx_tk = 1'b0;
      host_u.tick(3);
    end
    chk("tx valid", tx_v, 1'b0);
    chk("tx_fifo_flag", tx_fifo_flag, 1'b0);
    // reset in mid-run brings back the reset state
    host_u.tick(1);
    rst_n = 1'b0;
    host_u.tick(2);
    rst_n = 1'b1;
    host_u.tick(6);
    chk("ctrl", ctrl, CTRL_RESET);
    chk("div", cdiv, DIV_RESET);
    chk("flags", {rx_fifo_flag, tx_fifo_flag}, 2'b11);
    // receive path with label filtering, empty polarity
    cmd(OP_CTRL_WR, 32'h0, CTRL_BITS);
    cmd(OP_LBL_SET, 32'h0, 0);
    cmd(OP_LBL_CLR, 32'h0, 0);
    push(32'h1234565A);
    chk("rx_fifo_flag", rx_fifo_flag, 1'b1);
    cmd(OP_LBL_SET1, 32'h5A, 8);
    push(32'h1234565A);
    push(32'h1234565B);
    chk("rx_fifo_flag", rx_fifo_flag, 1'b0);
    cmd(OP_RX_RD, 32'h0, WORD_BITS);
    chk("rx word", rd, 32'h1234565A);
    cmd(OP_RX_RD, 32'h0, WORD_BITS);
    chk("rx empty", rd, 32'h0);
    cmd(OP_LBL_RST1, 32'h5A, 8);
    push(32'h1234565A);
    chk("rx_fifo_flag", rx_fifo_flag, 1'b1);
    // bulk table write, label FF first, then read back
    host_u.open_frame();
    host_u.shift({24'h0, OP_LBL_WR}, 8, rd);
    for (int i = 0; i < 8; i++) host_u.shift(lbl_pat(i), WORD_BITS, rd);
    host_u.close_frame();
    host_u.open_frame();
    host_u.shift({24'h0, OP_LBL_RD}, 8, rd);
    for (int i = 0; i < 8; i++)
    begin
      host_u.shift(32'h0, WORD_BITS, rd);
      chk("label table", rd, lbl_pat(i));
    end
    host_u.close_frame();
    push(32'h000000FE);
    chk("rx_fifo_flag", rx_fifo_flag, 1'b1);
    push(32'h000000FD);
    chk("rx_fifo_flag", rx_fifo_flag, 1'b0);
    cmd(OP_RX_RD, 32'h0, WORD_BITS);
    chk("rx word", rd, 32'h000000FD);
    // label bit order reversed: label 01 is enabled along with FF, FD, FC and 00
    cmd(OP_CTRL_WR, 32'h1000, CTRL_BITS);
    cmd(OP_LBL_SET1, 32'h01, 8);
    push(32'h12345601);
    chk("rx_fifo_flag", rx_fifo_flag, 1'b1);
    push(32'h12345680);
    chk("rx_fifo_flag", rx_fifo_flag, 1'b0);
    cmd(OP_RX_DUMP, 32'h0, WORD_BITS);
    chk("dump", rd[31:8], 24'h123456);
    cmd(OP_RX_RD, 32'h0, WORD_BITS);
    chk("rx empty", rd, 32'h0);
    // parity in bit 32; this word then waits for the master reset
    cmd(OP_CTRL_WR, 32'h0010, CTRL_BITS);
    cmd(OP_TX_WR, 32'h0000_0003, WORD_BITS);
    chk("tx parity", tx_w, 32'h8000_0003);
    chk("tx valid", tx_v, 1'b1);
    chk("tx_fifo_flag", tx_fifo_flag, 1'b0);
    // master reset by pin, then by op code
    cmd(OP_LBL_SET, 32'h0, 0);
    push(32'h000000C3);
    host_u.tick(1);
    mr = 1'b1;
    host_u.tick(4);
    mr = 1'b0;
    host_u.tick(5);
    chk("rx_fifo_flag", rx_fifo_flag, 1'b1);
    chk("tx valid", tx_v, 1'b0);
    chk("tx_fifo_flag", tx_fifo_flag, 1'b1);
    cmd(OP_RX_RD, 32'h0, WORD_BITS);
    chk("rx mr", rd, 32'h0);
    push(32'h000000C3);
    cmd(OP_MRESET, 32'h0, 0);
    chk("rx_fifo_flag", rx_fifo_flag, 1'b1);
    final_report();
  end
endmodule // sbt_spi_port_test
`default_nettype wire
